//--- rtl/chsfl_defs.vh
// Register offsets, bit positions and state codes of the status block
`ifndef CHSFL_DEFS_VH
`define CHSFL_DEFS_VH

`define CHSFL_ADDR_FAULT     8'h20
`define CHSFL_ADDR_OPSTATE   8'h21
`define CHSFL_ADDR_EXITSTAT  8'h23

`define CHSFL_BYTE_RESET     8'h00
`define CHSFL_ZERO3          3'h0

// Fault byte fields
`define CHSFL_F_INOV         7
`define CHSFL_F_BATTERY_OVERCURRENT_FAULT        6
`define CHSFL_F_INOC         5
`define CHSFL_F_SYSOV        4
`define CHSFL_F_SYSUV        3
`define CHSFL_F_FORCE        2
`define CHSFL_F_SRCOV        1
`define CHSFL_F_SRCUV        0

// Operating state byte fields
`define CHSFL_S_ASSIST       5
`define CHSFL_S_VREG         4
`define CHSFL_S_IREG         3
`define CHSFL_S_FAST         2
`define CHSFL_S_SOURCE       0

// Assist exit flag position in its byte
`define CHSFL_X_EXIT         0

// Synchronised input vector positions
`define CHSFL_I_MODEPIN      0
`define CHSFL_I_INOV         1
`define CHSFL_I_INOC         2
`define CHSFL_I_BATTERY_OVERCURRENT_FAULT        3
`define CHSFL_I_BATOV        4
`define CHSFL_I_SYSOV        5
`define CHSFL_I_SYSUV        6
`define CHSFL_I_RSTFAIL      7
`define CHSFL_I_VINREG       8
`define CHSFL_I_VOUTREG      9
`define CHSFL_I_IINREG       10
`define CHSFL_I_FAST         11
`define CHSFL_I_SOURCE       12
`define CHSFL_I_SRCOV        13
`define CHSFL_I_SRCUV        14
`define CHSFL_I_ADAPTER      15
`define CHSFL_SYNC_W         16
`define CHSFL_SYNC_RESET     16'h0000

// Restart attempts before the undervoltage fault latches
`define CHSFL_UV_TRIES       3'h7

// Assist mode states
`define CHSFL_ST_OFF         2'h0
`define CHSFL_ST_ON          2'h1
`define CHSFL_ST_LOCK        2'h2

`endif

//--- rtl/chsfl_status.v
// Charger status bytes, latched fault flags and power-assist mode control
`include "chsfl_defs.vh"

module chsfl_status
(
    input  wire       clk_sys,
    input  wire       rst_b,
    input  wire       reg_rd,
    input  wire       reg_wr,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    input  wire       shared_mode_pin,
    input  wire       input_overvoltage_fault,
    input  wire       input_overcurrent_fault,
    input  wire       battery_overcurrent_fault,
    input  wire       battery_overvoltage,
    input  wire       system_overvoltage_fault,
    input  wire       system_undervoltage_fault,
    input  wire       restart_failed,
    input  wire       input_volt_reg_active,
    input  wire       output_volt_reg_active,
    input  wire       input_curr_reg_active,
    input  wire       fast_charge_active,
    input  wire       source_mode_active,
    input  wire       source_overvoltage_fault,
    input  wire       source_undervoltage_fault,
    input  wire       adapter_present,
    input  wire       assist_disable,
    input  wire       converter_force_off,
    input  wire       batt_overcurrent_enable,
    input  wire       pass_through_mode,
    input  wire       adapter_ok_throttle_profile,
    input  wire       system_volt_throttle_profile,
    output wire       assist_active,
    output reg        regulation_enable,
    output reg        adapter_profile_off,
    output reg        vsys_profile_on,
    output reg        converter_enable,
    output wire       processor_hot_out,
    output wire       processor_hot_oe
);

    // Assist mode state codes
    localparam [1:0] ST_OFF  = `CHSFL_ST_OFF;
    localparam [1:0] ST_ON   = `CHSFL_ST_ON;
    localparam [1:0] ST_LOCK = `CHSFL_ST_LOCK;

    // Address match used by read and write paths
    function hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    wire [`CHSFL_SYNC_W-1:0] raw_in;
    reg  [`CHSFL_SYNC_W-1:0] sync_a;
    reg  [`CHSFL_SYNC_W-1:0] sync_b;
    reg  [`CHSFL_SYNC_W-1:0] sync_d;
    reg  [1:0]               state;
    reg  [1:0]               next_state;
    reg  [7:0]               fault;
    reg  [7:0]               next_fault;
    reg                      assist_exit_flag;
    reg                      next_exit_flag;
    reg  [2:0]               uv_tries;
    reg  [2:0]               next_uv_tries;
    reg                      assist_q;
    reg  [7:0]               opstate;
    reg  [7:0]               read_val;

    wire assist_req;
    wire any_fault;
    wire battery_overcurrent_fault_trig;
    wire rd_fault;
    wire wr_fault;
    wire wr_exit;
    wire fail_edge;
    wire adapter_gone;
    wire assist_rise;
    wire assist_fall;

    assign raw_in = {adapter_present, source_undervoltage_fault,
                     source_overvoltage_fault, source_mode_active,
                     fast_charge_active, input_curr_reg_active,
                     output_volt_reg_active, input_volt_reg_active,
                     restart_failed, system_undervoltage_fault,
                     system_overvoltage_fault, battery_overvoltage,
                     battery_overcurrent_fault, input_overcurrent_fault,
                     input_overvoltage_fault, shared_mode_pin};

    // Two-stage synchroniser plus a delayed copy for edges
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync_a <= `CHSFL_SYNC_RESET;
            sync_b <= `CHSFL_SYNC_RESET;
            sync_d <= `CHSFL_SYNC_RESET;
        end
        else
        begin
            sync_a <= raw_in;
            sync_b <= sync_a;
            sync_d <= sync_b;
        end
    end

    assign rd_fault = reg_rd & hit(reg_addr, `CHSFL_ADDR_FAULT);
    assign wr_fault = reg_wr & hit(reg_addr, `CHSFL_ADDR_FAULT);
    assign wr_exit  = reg_wr & hit(reg_addr, `CHSFL_ADDR_EXITSTAT);
    assign fail_edge = sync_b[`CHSFL_I_RSTFAIL] & ~sync_d[`CHSFL_I_RSTFAIL];
    assign adapter_gone = ~sync_b[`CHSFL_I_ADAPTER]
                        & sync_d[`CHSFL_I_ADAPTER];

    // Host command alone; processor-hot state is not an input here
    assign assist_req = sync_b[`CHSFL_I_MODEPIN]
                      & ~assist_disable;

    assign any_fault = sync_b[`CHSFL_I_INOV] | sync_b[`CHSFL_I_INOC]
                     | sync_b[`CHSFL_I_SYSOV] | sync_b[`CHSFL_I_BATOV]
                     | fault[`CHSFL_F_SYSUV];

    // Battery fault qualification in pass-through mode
    assign battery_overcurrent_fault_trig = pass_through_mode
        ? (batt_overcurrent_enable & (sync_b[`CHSFL_I_BATTERY_OVERCURRENT_FAULT]
           | sync_b[`CHSFL_I_BATOV]))
        : sync_b[`CHSFL_I_BATTERY_OVERCURRENT_FAULT];

    // Assist mode state machine
    always @*
    begin
        next_state = state;
        next_exit_flag = assist_exit_flag;
        case (state)
            ST_OFF:
            begin
                if (assist_req)
                    next_state = ST_ON;
            end
            ST_ON:
            begin
                if (any_fault)
                begin
                    next_state = ST_LOCK;
                    next_exit_flag = 1'b1;
                end
                else if (!assist_req)
                    next_state = ST_OFF;
            end
            ST_LOCK:
            begin
                if (!assist_req)
                    next_state = ST_OFF;
            end
            default:
                next_state = ST_OFF;
        endcase
        // Write 0 clears; a new fault exit in the same cycle wins
        if (wr_exit && !reg_wdata[`CHSFL_X_EXIT]
            && !(state == ST_ON && any_fault))
            next_exit_flag = 1'b0;
    end

    // Fault latches
    always @*
    begin
        next_fault = fault;
        next_uv_tries = uv_tries;
        // Read clears after the value was captured for the read data
        if (rd_fault)
        begin
            next_fault[`CHSFL_F_INOV]  = 1'b0;
            next_fault[`CHSFL_F_BATTERY_OVERCURRENT_FAULT] = 1'b0;
            next_fault[`CHSFL_F_INOC]  = 1'b0;
            next_fault[`CHSFL_F_FORCE] = 1'b0;
            next_fault[`CHSFL_F_SRCOV] = 1'b0;
            next_fault[`CHSFL_F_SRCUV] = 1'b0;
        end
        if (wr_fault && !reg_wdata[`CHSFL_F_SYSOV])
            next_fault[`CHSFL_F_SYSOV] = 1'b0;
        if (adapter_gone)
            next_fault[`CHSFL_F_SYSOV] = 1'b0;
        if (wr_fault && !reg_wdata[`CHSFL_F_SYSUV])
        begin
            next_fault[`CHSFL_F_SYSUV] = 1'b0;
            next_uv_tries = `CHSFL_ZERO3;
        end
        // Restart attempt counting under undervoltage
        if (!sync_b[`CHSFL_I_SYSUV])
            next_uv_tries = `CHSFL_ZERO3;
        else if (fail_edge && uv_tries != `CHSFL_UV_TRIES)
            next_uv_tries = uv_tries + 3'h1;
        if (uv_tries == `CHSFL_UV_TRIES && sync_b[`CHSFL_I_SYSUV])
            next_fault[`CHSFL_F_SYSUV] = 1'b1;
        // Sets take priority over every clear
        if (sync_b[`CHSFL_I_INOV])
            next_fault[`CHSFL_F_INOV] = 1'b1;
        if (battery_overcurrent_fault_trig)
            next_fault[`CHSFL_F_BATTERY_OVERCURRENT_FAULT] = 1'b1;
        if (sync_b[`CHSFL_I_INOC])
            next_fault[`CHSFL_F_INOC] = 1'b1;
        if (sync_b[`CHSFL_I_SYSOV])
            next_fault[`CHSFL_F_SYSOV] = 1'b1;
        if (converter_force_off)
            next_fault[`CHSFL_F_FORCE] = 1'b1;
        if (sync_b[`CHSFL_I_SRCOV])
            next_fault[`CHSFL_F_SRCOV] = 1'b1;
        if (sync_b[`CHSFL_I_SRCUV])
            next_fault[`CHSFL_F_SRCUV] = 1'b1;
    end

    // Operating state byte
    always @*
    begin
        opstate = `CHSFL_BYTE_RESET;
        opstate[`CHSFL_S_ASSIST] = assist_active;
        opstate[`CHSFL_S_VREG] = sync_b[`CHSFL_I_SOURCE]
            ? sync_b[`CHSFL_I_VOUTREG]
            : sync_b[`CHSFL_I_VINREG];
        opstate[`CHSFL_S_IREG] = sync_b[`CHSFL_I_IINREG];
        opstate[`CHSFL_S_FAST] = sync_b[`CHSFL_I_FAST];
        opstate[`CHSFL_S_SOURCE] = sync_b[`CHSFL_I_SOURCE];
    end

    // Read mux; unmapped addresses read zero
    always @*
    begin
        read_val = `CHSFL_BYTE_RESET;
        if (hit(reg_addr, `CHSFL_ADDR_FAULT))
            read_val = fault;
        else if (hit(reg_addr, `CHSFL_ADDR_OPSTATE))
            read_val = opstate;
        else if (hit(reg_addr, `CHSFL_ADDR_EXITSTAT))
            read_val[`CHSFL_X_EXIT] = assist_exit_flag;
    end

    assign assist_active = (state == ST_ON);
    assign assist_rise = assist_active & ~assist_q;
    assign assist_fall = ~assist_active & assist_q;

    // Processor-hot open-drain: driven low while exit flag set
    assign processor_hot_out = 1'b0;
    assign processor_hot_oe  = assist_exit_flag;

    // Mode, flag and counter registers
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= ST_OFF;
            fault <= `CHSFL_BYTE_RESET;
            assist_exit_flag <= 1'b0;
            uv_tries <= `CHSFL_ZERO3;
            assist_q <= 1'b0;
        end
        else
        begin
            state <= next_state;
            fault <= next_fault;
            assist_exit_flag <= next_exit_flag;
            uv_tries <= next_uv_tries;
            assist_q <= assist_active;
        end
    end

    // Read data register; holds between reads
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_rdata <= `CHSFL_BYTE_RESET;
        end
        else if (reg_rd)
        begin
            reg_rdata <= read_val;
        end
    end

    // Regulation gate follows assist edges
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            regulation_enable <= 1'b1;
        end
        else if (assist_rise)
        begin
            regulation_enable <= 1'b0;
        end
        else if (assist_fall)
        begin
            regulation_enable <= 1'b1;
        end
    end

    // One-cycle throttle profile requests on assist entry
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            adapter_profile_off <= 1'b0;
            vsys_profile_on <= 1'b0;
        end
        else
        begin
            adapter_profile_off <= assist_rise
                & adapter_ok_throttle_profile;
            vsys_profile_on <= assist_rise
                & ~system_volt_throttle_profile;
        end
    end

    // Converter held off by latched overvoltage or force-off
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            converter_enable <= 1'b0;
        end
        else
        begin
            converter_enable <= ~next_fault[`CHSFL_F_SYSOV]
                & ~converter_force_off;
        end
    end

endmodule // chsfl_status

//--- tb/chsfl_host_model.sv
// Host side: register strobes and mode pin drive for the status block
module chsfl_host_model
(
    input  logic       req_rd,
    input  logic       req_wr,
    input  logic [7:0] req_addr,
    input  logic [7:0] req_wdata,
    input  logic       req_pin,
    input  logic       req_dis,
    output logic       reg_rd,
    output logic       reg_wr,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic       shared_mode_pin,
    output logic       assist_disable
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus lines show the inverse of the last value
    assign reg_rd          = req_rd;
    assign reg_wr          = req_wr;
    assign reg_addr        = (req_rd | req_wr) ? req_addr : ~req_addr;
    assign reg_wdata       = req_wr ? req_wdata : ~req_wdata;
    assign shared_mode_pin = req_pin;
    assign assist_disable  = req_dis;
endmodule // chsfl_host_model

//--- tb/chsfl_status_monitor.sv
// Concurrent checks on the status block ports
module chsfl_status_monitor
(
    input logic       clk_sys,
    input logic       rst_b,
    input logic       reg_wr,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic       shared_mode_pin,
    input logic       assist_disable,
    input logic       input_overvoltage_fault,
    input logic       system_overvoltage_fault,
    input logic       system_volt_throttle_profile,
    input logic       adapter_ok_throttle_profile,
    input logic       adapter_profile_off,
    input logic       assist_active,
    input logic       regulation_enable,
    input logic       vsys_profile_on,
    input logic       converter_enable,
    input logic       processor_hot_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_assist_entry: assert property (
        $rose(assist_active) |-> $past(shared_mode_pin, 3)
        && !$past(assist_disable)) else $error("assist entry without request");
    a_assist_exit: assert property (
        assist_active && (assist_disable || !$past(shared_mode_pin, 2))
        |=> !assist_active) else $error("assist kept after release");
    a_fault_exit: assert property (
        assist_active && $past(input_overvoltage_fault, 2)
        |=> !assist_active && processor_hot_oe) else $error("no fault exit");
    a_phot_hold: assert property (
        processor_hot_oe && !(reg_wr && reg_addr == 8'h23 && !reg_wdata[0])
        |=> processor_hot_oe) else $error("processor hot released early");
    a_reg_off: assert property (
        assist_active |=> !regulation_enable) else $error("regulation on");
    a_reg_on: assert property (
        !assist_active |=> regulation_enable) else $error("regulation off");
    a_vsys_pulse: assert property (
        $rose(assist_active) && !system_volt_throttle_profile
        |-> ##[0:2] vsys_profile_on) else $error("no vsys profile pulse");
    a_sysov_conv: assert property (
        system_overvoltage_fault |-> ##4 !converter_enable)
        else $error("converter on in system overvoltage");
    a_adapter_off: assert property (
        $rose(assist_active) && adapter_ok_throttle_profile
        |=> adapter_profile_off) else $error("no adapter profile pulse");
    a_profile_once: assert property (
        (adapter_profile_off || vsys_profile_on)
        |-> $past(assist_active) && !$past(assist_active, 2))
        else $error("profile pulse without assist entry");
    a_profile_skip: assert property (
        $rose(assist_active) && !adapter_ok_throttle_profile
        && system_volt_throttle_profile
        |=> !adapter_profile_off && !vsys_profile_on)
        else $error("profile pulse not needed");
    cover property ($rose(assist_active));
    cover property ($rose(processor_hot_oe));
    cover property ($fell(converter_enable));
endmodule // chsfl_status_monitor

//--- tb/chsfl_status_bench.sv
// Self-checking bench for the charger status block
module chsfl_status_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, rst_b = 0, req_rd = 0, req_wr = 0;
    logic req_pin = 0, req_dis = 0;
    logic [7:0] req_addr = 8'h00, req_wdata = 8'h00;
    logic [4:0] r;
    logic input_overvoltage_fault = 0, input_overcurrent_fault = 0;
    logic battery_overcurrent_fault = 0, battery_overvoltage = 0;
    logic system_overvoltage_fault = 0, system_undervoltage_fault = 0;
    logic restart_failed = 0, input_volt_reg_active = 0;
    logic output_volt_reg_active = 0, input_curr_reg_active = 0;
    logic fast_charge_active = 0, source_mode_active = 0;
    logic source_overvoltage_fault = 0, source_undervoltage_fault = 0;
    logic adapter_present = 1, converter_force_off = 0;
    logic batt_overcurrent_enable = 0, pass_through_mode = 0;
    logic adapter_ok_throttle_profile = 1, system_volt_throttle_profile = 0;
    wire reg_rd, reg_wr, shared_mode_pin, assist_disable, assist_active;
    wire regulation_enable, adapter_profile_off, vsys_profile_on;
    wire converter_enable, processor_hot_out, processor_hot_oe;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    int error_cnt = 0, checked = 0, seed = 32'h6240;
    logic [7:0] q[$];
    chsfl_host_model u_chsfl_host_model (.req_rd, .req_wr, .req_addr,
        .req_wdata, .req_pin, .req_dis, .reg_rd, .reg_wr, .reg_addr,
        .reg_wdata, .shared_mode_pin, .assist_disable);
    chsfl_status u_chsfl_status (.clk_sys, .rst_b, .reg_rd, .reg_wr,
        .reg_addr, .reg_wdata, .reg_rdata, .shared_mode_pin,
        .input_overvoltage_fault, .input_overcurrent_fault,
        .battery_overcurrent_fault, .battery_overvoltage,
        .system_overvoltage_fault, .system_undervoltage_fault,
        .restart_failed, .input_volt_reg_active, .output_volt_reg_active,
        .input_curr_reg_active, .fast_charge_active, .source_mode_active,
        .source_overvoltage_fault, .source_undervoltage_fault,
        .adapter_present, .assist_disable, .converter_force_off,
        .batt_overcurrent_enable, .pass_through_mode,
        .adapter_ok_throttle_profile, .system_volt_throttle_profile,
        .assist_active, .regulation_enable, .adapter_profile_off,
        .vsys_profile_on, .converter_enable, .processor_hot_out,
        .processor_hot_oe);
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        q.push_back(e);
        req_addr = a;
        req_rd = 1;
        @(negedge clk_sys);
        req_rd = 0;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        req_addr = a;
        req_wdata = d;
        req_wr = 1;
        @(negedge clk_sys);
        req_wr = 0;
    endtask
    task restart_pulse;
        restart_failed = 1;
        cyc(2);
        restart_failed = 0;
        cyc(2);
    endtask
    // Read data compared one edge after each read strobe
    always @(posedge clk_sys)
        if (reg_rd === 1'b1)
        begin
            @(negedge clk_sys);
            chk(reg_rdata, q.pop_front());
        end
    initial
        forever #5 clk_sys = ~clk_sys;
    initial
    begin
        #200us;
        error_cnt++;
        close_out;
    end
    initial
    begin
        cyc(8);
        rst_b = 1;
        rd(8'h20, 8'h00);
        rd(8'h21, 8'h00);
        rd(8'h55, 8'h00);
        repeat (6)
        begin
            r = 5'($random(seed));
            {input_volt_reg_active, output_volt_reg_active} = r[4:3];
            {input_curr_reg_active, fast_charge_active} = r[2:1];
            source_mode_active = r[0];
            cyc(4);
            rd(8'h21, {3'h0, r[0]?r[3]:r[4], r[2:1], 1'b0, r[0]});
        end
        {input_volt_reg_active, output_volt_reg_active} = 2'h0;
        {input_curr_reg_active, fast_charge_active} = 2'h0;
        source_mode_active = 0;
        {input_overvoltage_fault, input_overcurrent_fault} = 2'h3;
        battery_overcurrent_fault = 1;
        {source_overvoltage_fault, source_undervoltage_fault} = 2'h3;
        cyc(4);
        {input_overvoltage_fault, input_overcurrent_fault} = 2'h0;
        battery_overcurrent_fault = 0;
        {source_overvoltage_fault, source_undervoltage_fault} = 2'h0;
        cyc(3);
        rd(8'h20, 8'hE3);
        rd(8'h20, 8'h00);
        converter_force_off = 1;
        cyc(2);
        chk(8'(converter_enable), 8'h00);
        rd(8'h20, 8'h04);
        rd(8'h20, 8'h04);
        converter_force_off = 0;
        cyc(1);
        rd(8'h20, 8'h04);
        rd(8'h20, 8'h00);
        {pass_through_mode, batt_overcurrent_enable} = 2'h3;
        battery_overvoltage = 1;
        cyc(4);
        battery_overvoltage = 0;
        cyc(3);
        rd(8'h20, 8'h40);
        batt_overcurrent_enable = 0;
        battery_overcurrent_fault = 1;
        cyc(4);
        battery_overcurrent_fault = 0;
        cyc(3);
        rd(8'h20, 8'h00);
        pass_through_mode = 0;
        system_overvoltage_fault = 1;
        cyc(5);
        chk(8'(converter_enable), 8'h00);
        system_overvoltage_fault = 0;
        cyc(4);
        rd(8'h20, 8'h10);
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h10);
        chk(8'(converter_enable), 8'h00);
        wr(8'h20, 8'h00);
        cyc(2);
        rd(8'h20, 8'h00);
        chk(8'(converter_enable), 8'h01);
        system_overvoltage_fault = 1;
        cyc(4);
        system_overvoltage_fault = 0;
        cyc(4);
        adapter_present = 0;
        cyc(4);
        rd(8'h20, 8'h00);
        adapter_present = 1;
        system_undervoltage_fault = 1;
        cyc(3);
        repeat (6) restart_pulse;
        cyc(2);
        rd(8'h20, 8'h00);
        restart_pulse;
        cyc(2);
        rd(8'h20, 8'h08);
        rd(8'h20, 8'h08);
        system_undervoltage_fault = 0;
        cyc(3);
        wr(8'h20, 8'h00);
        rd(8'h20, 8'h00);
        req_pin = 1;
        cyc(5);
        chk(8'(assist_active), 8'h01);
        rd(8'h21, 8'h20);
        req_dis = 1;
        cyc(2);
        chk(8'(assist_active), 8'h00);
        rd(8'h23, 8'h00);
        req_dis = 0;
        cyc(2);
        chk(8'(assist_active), 8'h01);
        req_pin = 0;
        cyc(4);
        chk(8'(assist_active), 8'h00);
        req_pin = 1;
        cyc(5);
        input_overvoltage_fault = 1;
        cyc(4);
        chk({assist_active, processor_hot_oe}, 8'h01);
        chk(8'(processor_hot_out), 8'h00);
        input_overvoltage_fault = 0;
        cyc(3);
        rd(8'h23, 8'h01);
        rd(8'h20, 8'h80);
        rd(8'h23, 8'h01);
        req_pin = 0;
        {adapter_ok_throttle_profile, system_volt_throttle_profile} = 2'h1;
        cyc(2);
        req_pin = 1;
        cyc(5);
        chk({assist_active, processor_hot_oe}, 8'h03);
        wr(8'h23, 8'h00);
        cyc(1);
        chk(8'(processor_hot_oe), 8'h00);
        req_pin = 0;
        cyc(5);
        close_out;
    end
endmodule // chsfl_status_bench

bind chsfl_status chsfl_status_monitor u_chsfl_status_monitor (.clk_sys,
    .rst_b, .reg_wr, .reg_addr, .reg_wdata, .shared_mode_pin,
    .assist_disable, .input_overvoltage_fault, .system_overvoltage_fault,
    .system_volt_throttle_profile, .adapter_ok_throttle_profile,
    .adapter_profile_off, .assist_active, .regulation_enable,
    .vsys_profile_on, .converter_enable, .processor_hot_oe);
